//--- logic/cmc_charge_mode_controller.sv
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// What this block does
// R1: Inhibit forces zero current and voltage request
// R2: Inhibit state raises charge inhibited flag
// R3: Inhibit option turns charge FETs off
// R4: Leave inhibit inside hysteresis band, restore FETs
// R5: Clear inhibit flag on exit, fault, removal
// R6: Precharge on cool temperature or low cell
// R7: Undervolt or discharge overcurrent forces precharge
// R8: Two-bit field selects precharge FET action
// R9: Precharge flag clears on recovery, suspend, fault
// R10: Fast charge when temperature, cells, pack fit
// R11: Fast flag set, charge FET on unless protection
// R12: Fast charge current follows temperature bands
// R13: Top band: precharge current, top throttle flag
// R14: Middle band: half difference, mid throttle flag
// R15: Low band: full fast current, flags clear
// R16: Extra hysteresis entering mid and top bands
// R17: Throttle flags clear on mode change, protection
// R18: Zero delta disables throttling
// R19: Limits are signed tenths of a degree
module cmc_charge_mode_controller
  import cmc_pkg::*;
#(
  parameter int CELLS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Measurement inputs, same clock domain
  input wire logic tick,
  input wire logic signed [15:0] temperature,
  input wire logic [CELLS*16-1:0] per_cell_voltage,
  input wire logic [15:0] pack_voltage,
  input wire logic cell_undervolt_flag,
  input wire logic pack_undervolt_flag,
  input wire logic discharge_overcurrent_flag,
  input wire logic discharge_overcurrent_tier2_flag,
  input wire logic fault_detected,
  input wire logic protection_detected,
  input wire logic suspend_entry,
  input wire logic battery_removed,
  // Requested values and status
  output logic [15:0] charging_current,
  output logic [15:0] charging_voltage,
  output logic [4:0] charge_state_word,
  // FET controls
  output logic charge_fet,
  output logic zero_volt_charge_fet,
  output logic open_drain_pin,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt
  output logic irq
);
  // Signed compare helper on widened values
  function automatic logic signed [17:0] sx(input logic signed [15:0] v);
    sx = {{2{v[15]}}, v};
  endfunction
  // Configuration registers
  logic [3:0] ctrl, next_ctrl;
  logic signed [15:0] inh_lo, inh_hi, hys, pre_temp, susp_hi, delta;
  logic signed [15:0] next_inh_lo, next_inh_hi, next_hys, next_pre_temp, next_susp_hi, next_delta;
  logic [15:0] pre_volt, rec_volt, pre_cur, fast_volt, fast_cur, ovc_volt;
  logic [15:0] next_pre_volt, next_rec_volt, next_pre_cur, next_fast_volt, next_fast_cur, next_ovc_volt;
  logic [4:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic [31:0] next_dat;
  logic next_ack, next_irq;
  // Mode state
  cmc_mode_t mode, next_mode;
  cmc_band_t band, next_band;
  logic saved_chg, saved_zv, next_saved_chg, next_saved_zv;
  logic [15:0] next_cur, next_volt;
  logic [4:0] next_state_word;
  logic next_chg, next_zv, next_od;
  // Derived conditions
  logic any_cell_low, all_cells_rec, safety_pre, removal, clr_evt;
  logic signed [17:0] t, mid_lo, top_lo;
  // Cell scans
  always_comb begin
    any_cell_low = 1'b0;
    all_cells_rec = 1'b1;
    for (int i = 0; i < CELLS; i++) begin
      if (per_cell_voltage[i*16 +: 16] < pre_volt) begin
        any_cell_low = 1'b1;
      end
      if (per_cell_voltage[i*16 +: 16] < rec_volt) begin
        all_cells_rec = 1'b0;
      end
    end
  end
  // Thresholds in widened signed form
  always_comb begin
    t = sx(temperature);
    top_lo = sx(susp_hi) - sx(delta);
    mid_lo = sx(susp_hi) - sx(delta) - sx(delta);
    // R7: safety flags force precharge
    safety_pre = cell_undervolt_flag | pack_undervolt_flag | discharge_overcurrent_flag |
                 discharge_overcurrent_tier2_flag;
    removal = battery_removed & ~ctrl[CTRL_NR];
    // R5: fault or removal ends inhibit
    clr_evt = fault_detected | removal;
  end

  // Charge mode next state
  always_comb begin
    next_mode = mode;
    next_band = band;
    next_saved_chg = saved_chg;
    next_saved_zv = saved_zv;
    next_chg = charge_fet;
    next_zv = zero_volt_charge_fet;
    next_od = open_drain_pin;
    next_cur = charging_current;
    next_volt = charging_voltage;
    if (tick) begin
      case (mode)
        CMC_INHIBIT: begin
          // R4: exit inside hysteresis band, or on fault or removal
          if ((t >= sx(inh_lo) + sx(hys) && t <= sx(inh_hi) - sx(hys)) || clr_evt) begin
            // R7: a pending safety flag goes straight to precharge
            next_mode = safety_pre ? CMC_PRE : CMC_IDLE;
            next_chg = saved_chg;
            next_zv = saved_zv;
          end
        end
        default: begin
          // R1: temperature outside inhibit limits
          if (t < sx(inh_lo) || t > sx(inh_hi)) begin
            next_mode = CMC_INHIBIT;
            next_saved_chg = charge_fet;
            next_saved_zv = zero_volt_charge_fet;
            // R3: optional FET shutdown
            if (ctrl[CTRL_INH_FET]) begin
              next_chg = 1'b0;
              next_zv = 1'b0;
            end
          // R6: precharge entry
          end else if ((t < sx(pre_temp)) || any_cell_low || safety_pre ||
                       (mode == CMC_PRE && !(t >= sx(pre_temp) + sx(hys) && all_cells_rec))) begin
            next_mode = CMC_PRE;
          // R10: fast charge entry
          end else if (t < mid_lo && ({1'b0, pack_voltage} <= {1'b0, fast_volt} + {1'b0, ovc_volt})) begin
            next_mode = CMC_FAST;
          end else if (mode != CMC_FAST) begin
            next_mode = CMC_IDLE;
          end
        end
      endcase
      // R9: precharge cleared by suspend or fault
      if (next_mode == CMC_PRE && (suspend_entry || clr_evt)) begin
        next_mode = CMC_IDLE;
      end
      // R12: temperature band selection
      if (next_mode != CMC_FAST || protection_detected || (battery_removed & ctrl[CTRL_NR])) begin
        // R17: leaving fast or protection clears throttle
        next_band = CMC_FULL;
      end else if (delta == 16'sh0000) begin
        // R18: throttling disabled
        next_band = CMC_FULL;
      end else begin
        case (band)
          CMC_FULL: begin
            // R16: extra hysteresis to enter middle
            if (t >= top_lo + sx(hys)) begin
              next_band = CMC_TOP;
            end else if (t >= mid_lo + sx(hys)) begin
              next_band = CMC_MID;
            end
          end
          CMC_MID: begin
            // R16: extra hysteresis to enter top
            if (t >= top_lo + sx(hys)) begin
              next_band = CMC_TOP;
            end else if (t < mid_lo) begin
              next_band = CMC_FULL;
            end
          end
          default: begin
            if (t < mid_lo) begin
              next_band = CMC_FULL;
            end else if (t < top_lo) begin
              next_band = CMC_MID;
            end
          end
        endcase
      end
      // Requested values
      case (next_mode)
        CMC_INHIBIT: begin
          // R1: zero request
          next_cur = 16'h0000;
          next_volt = 16'h0000;
        end
        CMC_PRE: begin
          next_cur = pre_cur;
          next_volt = fast_volt;
        end
        CMC_FAST: begin
          next_volt = fast_volt;
          case (next_band)
            // R13: top band current
            CMC_TOP: next_cur = pre_cur;
            // R14: middle band current
            CMC_MID: next_cur = (fast_cur >= pre_cur) ? (fast_cur - pre_cur) >> 1 : 16'h0000;
            // R15: full current
            default: next_cur = fast_cur;
          endcase
        end
        default: begin
          next_cur = fast_cur;
          next_volt = fast_volt;
        end
      endcase
      // FET actions outside inhibit
      if (next_mode != CMC_INHIBIT && mode != CMC_INHIBIT) begin
        next_od = 1'b0;
        if (next_mode == CMC_PRE) begin
          // R8: precharge FET selector
          case ({ctrl[CTRL_SEL_HI], ctrl[CTRL_SEL_LO]})
            SEL_ZV: begin next_zv = 1'b1; next_chg = 1'b0; end
            SEL_CHG: begin next_chg = 1'b1; next_zv = 1'b0; end
            SEL_OD: next_od = 1'b1;
            default: ;
          endcase
        end else if (next_mode == CMC_FAST) begin
          // R11: charge FET on unless protection
          next_chg = ~protection_detected;
          next_zv = 1'b0;
        end
      end
    end
    // R2: flags follow state
    next_state_word = 5'h00;
    next_state_word[ST_INH] = (next_mode == CMC_INHIBIT);
    next_state_word[ST_PRE] = (next_mode == CMC_PRE);
    next_state_word[ST_FAST] = (next_mode == CMC_FAST);
    next_state_word[ST_TOP] = (next_band == CMC_TOP);
    next_state_word[ST_MID] = (next_band == CMC_MID);
  end

  // Mode registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode <= CMC_IDLE;
      band <= CMC_FULL;
      saved_chg <= 1'b0;
      saved_zv <= 1'b0;
      charge_fet <= 1'b0;
      zero_volt_charge_fet <= 1'b0;
      open_drain_pin <= 1'b0;
      charging_current <= FAST_CUR_RESET;
      charging_voltage <= FAST_VOLT_RESET;
      charge_state_word <= 5'h00;
    end else begin
      mode <= next_mode;
      band <= next_band;
      saved_chg <= next_saved_chg;
      saved_zv <= next_saved_zv;
      charge_fet <= next_chg;
      zero_volt_charge_fet <= next_zv;
      open_drain_pin <= next_od;
      charging_current <= next_cur;
      charging_voltage <= next_volt;
      charge_state_word <= next_state_word;
    end
  end

  // Bus decode and interrupt next values
  always_comb begin
    logic wr;
    logic [4:0] rise;
    wr = 1'b0;
    rise = 5'h00;
    next_ctrl = ctrl;
    next_inh_lo = inh_lo;
    next_inh_hi = inh_hi;
    next_hys = hys;
    next_pre_temp = pre_temp;
    next_pre_volt = pre_volt;
    next_rec_volt = rec_volt;
    next_pre_cur = pre_cur;
    next_fast_volt = fast_volt;
    next_fast_cur = fast_cur;
    next_ovc_volt = ovc_volt;
    next_susp_hi = susp_hi;
    next_delta = delta;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_dat = 32'h0000_0000;
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wr = next_ack & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
    // R19: temperature settings are signed tenths of a degree
    if (wb_adr_i == ADDR_CTRL) begin
      next_dat = {28'h0, ctrl};
      if (next_ack & wb_we_i & wb_sel_i[0]) next_ctrl = wb_dat_i[3:0];
    end else if (wb_adr_i == ADDR_INH_LO) begin
      next_dat = {16'h0, inh_lo};
      if (wr) next_inh_lo = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_INH_HI) begin
      next_dat = {16'h0, inh_hi};
      if (wr) next_inh_hi = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_HYS) begin
      next_dat = {16'h0, hys};
      if (wr) next_hys = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_PRE_TEMP) begin
      next_dat = {16'h0, pre_temp};
      if (wr) next_pre_temp = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_PRE_VOLT) begin
      next_dat = {16'h0, pre_volt};
      if (wr) next_pre_volt = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_REC_VOLT) begin
      next_dat = {16'h0, rec_volt};
      if (wr) next_rec_volt = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_PRE_CUR) begin
      next_dat = {16'h0, pre_cur};
      if (wr) next_pre_cur = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_FAST_VOLT) begin
      next_dat = {16'h0, fast_volt};
      if (wr) next_fast_volt = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_FAST_CUR) begin
      next_dat = {16'h0, fast_cur};
      if (wr) next_fast_cur = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_OVC_VOLT) begin
      next_dat = {16'h0, ovc_volt};
      if (wr) next_ovc_volt = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_SUSP_HI) begin
      next_dat = {16'h0, susp_hi};
      if (wr) next_susp_hi = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_DELTA) begin
      next_dat = {16'h0, delta};
      if (wr) next_delta = wb_dat_i[15:0];
    end else if (wb_adr_i == ADDR_STATE) begin
      next_dat = {25'h0, charge_fet, zero_volt_charge_fet, charge_state_word};
    end else if (wb_adr_i == ADDR_REQ) begin
      next_dat = {charging_voltage, charging_current};
    end else if (wb_adr_i == ADDR_IRQ_STAT) begin
      next_dat = {27'h0, irq_stat};
      if (next_ack & wb_we_i & wb_sel_i[0]) next_irq_stat = irq_stat & ~wb_dat_i[4:0];
    end else if (wb_adr_i == ADDR_IRQ_MASK) begin
      next_dat = {27'h0, irq_mask};
      if (next_ack & wb_we_i & wb_sel_i[0]) next_irq_mask = wb_dat_i[4:0];
    end
    // Status flags rising set sticky bits; set wins over clear
    rise = next_state_word & ~charge_state_word;
    next_irq_stat = next_irq_stat | rise;
    next_irq = |(next_irq_stat & next_irq_mask);
  end

  // Bus and interrupt registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTRL_RESET;
      inh_lo <= INH_LO_RESET;
      inh_hi <= INH_HI_RESET;
      hys <= HYS_RESET;
      pre_temp <= PRE_TEMP_RESET;
      pre_volt <= PRE_VOLT_RESET;
      rec_volt <= REC_VOLT_RESET;
      pre_cur <= PRE_CUR_RESET;
      fast_volt <= FAST_VOLT_RESET;
      fast_cur <= FAST_CUR_RESET;
      ovc_volt <= OVC_VOLT_RESET;
      susp_hi <= SUSP_HI_RESET;
      delta <= DELTA_RESET;
      irq_stat <= 5'h00;
      irq_mask <= 5'h00;
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
      irq <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      inh_lo <= next_inh_lo;
      inh_hi <= next_inh_hi;
      hys <= next_hys;
      pre_temp <= next_pre_temp;
      pre_volt <= next_pre_volt;
      rec_volt <= next_rec_volt;
      pre_cur <= next_pre_cur;
      fast_volt <= next_fast_volt;
      fast_cur <= next_fast_cur;
      ovc_volt <= next_ovc_volt;
      susp_hi <= next_susp_hi;
      delta <= next_delta;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
      irq <= next_irq;
    end
  end

endmodule

//--- logic/cmc_pkg.sv
package cmc_pkg;
  // Register byte offsets (Wishbone, one aligned word each)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_INH_LO = 8'h04;
  localparam logic [7:0] ADDR_INH_HI = 8'h08;
  localparam logic [7:0] ADDR_HYS = 8'h0c;
  localparam logic [7:0] ADDR_PRE_TEMP = 8'h10;
  localparam logic [7:0] ADDR_PRE_VOLT = 8'h14;
  localparam logic [7:0] ADDR_REC_VOLT = 8'h18;
  localparam logic [7:0] ADDR_PRE_CUR = 8'h1c;
  localparam logic [7:0] ADDR_FAST_VOLT = 8'h20;
  localparam logic [7:0] ADDR_FAST_CUR = 8'h24;
  localparam logic [7:0] ADDR_OVC_VOLT = 8'h28;
  localparam logic [7:0] ADDR_SUSP_HI = 8'h2c;
  localparam logic [7:0] ADDR_DELTA = 8'h30;
  localparam logic [7:0] ADDR_STATE = 8'h34;
  localparam logic [7:0] ADDR_REQ = 8'h38;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h3c;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h40;
  // Control word fields
  localparam int CTRL_INH_FET = 0;
  localparam int CTRL_NR = 1;
  localparam int CTRL_SEL_LO = 2;
  localparam int CTRL_SEL_HI = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  // Status word field positions
  localparam int ST_INH = 0;
  localparam int ST_PRE = 1;
  localparam int ST_FAST = 2;
  localparam int ST_TOP = 3;
  localparam int ST_MID = 4;
  // Reset values of settings (0.1 C, mV, mA)
  localparam logic signed [15:0] INH_LO_RESET = 16'sh0000;
  localparam logic signed [15:0] INH_HI_RESET = 16'sh01c2;
  localparam logic signed [15:0] HYS_RESET = 16'sh000a;
  localparam logic signed [15:0] PRE_TEMP_RESET = 16'sh0078;
  localparam logic [15:0] PRE_VOLT_RESET = 16'h0bb8;
  localparam logic [15:0] REC_VOLT_RESET = 16'h0c1c;
  localparam logic [15:0] PRE_CUR_RESET = 16'h00fa;
  localparam logic [15:0] FAST_VOLT_RESET = 16'h41a0;
  localparam logic [15:0] FAST_CUR_RESET = 16'h0fa0;
  localparam logic [15:0] OVC_VOLT_RESET = 16'h01f4;
  localparam logic signed [15:0] SUSP_HI_RESET = 16'sh0226;
  localparam logic signed [15:0] DELTA_RESET = 16'sh0032;
  // Precharge FET selector codes
  localparam logic [1:0] SEL_ZV = 2'h0;
  localparam logic [1:0] SEL_CHG = 2'h1;
  localparam logic [1:0] SEL_OD = 2'h2;
  // Charge modes
  typedef enum logic [1:0] {CMC_IDLE, CMC_INHIBIT, CMC_PRE, CMC_FAST} cmc_mode_t;
  // Throttle band
  typedef enum logic [1:0] {CMC_FULL, CMC_MID, CMC_TOP} cmc_band_t;
endpackage

//--- tb/cmc_charge_mode_controller_props.sv
`timescale 1ns/1ps
// Port-level checks on the charge mode controller
module cmc_charge_mode_controller_props
  import cmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Mode inputs
  input wire logic tick,
  input wire logic fault_detected,
  input wire logic protection_detected,
  input wire logic suspend_entry,
  input wire logic battery_removed,
  input wire logic cell_undervolt_flag,
  input wire logic pack_undervolt_flag,
  input wire logic discharge_overcurrent_flag,
  input wire logic discharge_overcurrent_tier2_flag,
  // Requests and status
  input wire logic [15:0] charging_current,
  input wire logic [15:0] charging_voltage,
  input wire logic [4:0] charge_state_word,
  input wire logic charge_fet,
  // Bus answer
  input wire logic wb_ack_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Tick taken while a fault is present
  sequence s_fault;
    tick && fault_detected;
  endsequence
  // Tick taken with a safety flag and no ending cause
  sequence s_safe;
    tick && (cell_undervolt_flag || pack_undervolt_flag || discharge_overcurrent_flag
      || discharge_overcurrent_tier2_flag) && !fault_detected && !suspend_entry && !battery_removed;
  endsequence
  a_inhibit_zero: assert property (
    charge_state_word[0] |-> charging_current == 16'h0000 && charging_voltage == 16'h0000)
    else $error("request not zero while inhibited");
  a_inhibit_tick: assert property (
    $rose(charge_state_word[0]) |-> $past(tick)) else $error("inhibit flag rose without tick");
  a_fault_clears: assert property (
    s_fault |=> !charge_state_word[0] && !charge_state_word[1]) else $error("fault left flag set");
  a_suspend_ends: assert property (
    tick && suspend_entry |=> !charge_state_word[1]) else $error("suspend left precharge");
  a_safety_pre: assert property (
    s_safe ##1 !charge_state_word[0] |-> charge_state_word[1]) else $error("no precharge on flag");
  a_fast_fet: assert property (
    (tick && !protection_detected) ##1 charge_state_word[2] |-> charge_fet) else $error("fast FET off");
  a_prot_throttle: assert property (
    tick && protection_detected |=> charge_state_word[4:3] == 2'h0) else $error("throttle kept");
  a_throttle_fast: assert property (
    |charge_state_word[4:3] |-> charge_state_word[2] && !(&charge_state_word[4:3]))
    else $error("bad throttle flags");
  // Acknowledge lasts one cycle
  a_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule

//--- tb/cmc_charger_model.sv
`timescale 1ns/1ps
// Charger side: takes up the requested values after each tick
module cmc_charger_model
  import cmc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Requests from the gauge
  input wire logic tick,
  input wire logic [15:0] charging_current,
  input wire logic [15:0] charging_voltage,
  // Values the charger acts on
  output logic [15:0] seen_cur,
  output logic [15:0] seen_volt
);
  logic tick_d; // Tick moved to the cycle the request is valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_d <= 1'b0;
      seen_cur <= 16'h0000;
      seen_volt <= 16'h0000;
    end else begin
      tick_d <= tick;
      // Requests settle one cycle after the tick
      if (tick_d) begin
        seen_cur <= charging_current;
        seen_volt <= charging_voltage;
      end
    end
  end
endmodule

//--- tb/test_charge_mode_controller.sv
`timescale 1ns/1ps
// Register-level bench of the charge mode controller
module test_charge_mode_controller
  import cmc_pkg::*;
;
  logic clk, reset_n, tick, prot; // Clock, reset, tick, protection
  logic signed [15:0] temperature; // Pack temperature
  logic [63:0] per_cell_voltage; // Four cells
  logic [15:0] pack_voltage, charging_current, charging_voltage, seen_cur, seen_volt;
  logic [3:0] sflags; // Safety flags
  logic [2:0] stop_src; // Fault, suspend, removal
  logic [4:0] sw; // Charge state word
  logic charge_fet, zero_volt_charge_fet, open_drain_pin, irq;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  int error_cnt, cmp_count, i;
  // Device under test
  cmc_charge_mode_controller uut (.clk(clk), .reset_n(reset_n), .tick(tick), .temperature(temperature),
    .per_cell_voltage(per_cell_voltage), .pack_voltage(pack_voltage), .cell_undervolt_flag(sflags[0]),
    .pack_undervolt_flag(sflags[1]), .discharge_overcurrent_flag(sflags[2]),
    .discharge_overcurrent_tier2_flag(sflags[3]), .fault_detected(stop_src[0]), .protection_detected(prot),
    .suspend_entry(stop_src[1]), .battery_removed(stop_src[2]), .charging_current(charging_current),
    .charging_voltage(charging_voltage), .charge_state_word(sw), .charge_fet(charge_fet),
    .zero_volt_charge_fet(zero_volt_charge_fet), .open_drain_pin(open_drain_pin), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));
  // Charger reading the requests
  cmc_charger_model u_chg (.clk(clk), .reset_n(reset_n), .tick(tick), .charging_current(charging_current),
    .charging_voltage(charging_voltage), .seen_cur(seen_cur), .seen_volt(seen_volt));
  // Clock of 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts, verdict, end of run
  task wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // One classic Wishbone cycle, held until ack
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    // Bus hang ends the run
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      wrap_up();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  // One measurement tick, then settle
  task step(input logic [15:0] t, input logic [15:0] cv);
    @(posedge clk);
    temperature <= t;
    per_cell_voltage <= {4{cv}};
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0; tick = 1'b0; prot = 1'b0; sflags = 4'h0; stop_src = 3'h0;
    temperature = 16'sh00c8; per_cell_voltage = {4{16'h0e10}}; pack_voltage = 16'h3e80;
    wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00; wb_sel_i = 4'hf; wb_dat_i = 32'h0;
    error_cnt = 0; cmp_count = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk({charging_voltage, charging_current}, 32'h41a00fa0);
    // Defaults, then an unmapped place
    wb(1'b0, ADDR_INH_HI, 32'h0); chk(q, 32'h01c2);
    wb(1'b0, ADDR_HYS, 32'h0); chk(q, 32'h000a);
    wb(1'b0, 8'h44, 32'h0); chk(q, 32'h0);
    // Inhibit with FET option and interrupt
    wb(1'b1, ADDR_CTRL, 32'h1); wb(1'b1, ADDR_IRQ_MASK, 32'h1);
    step(16'hfff6, 16'h0e10);
    chk({seen_volt, seen_cur}, 32'h0);
    chk(sw[0], 1'b1);
    chk({charge_fet, zero_volt_charge_fet}, 2'h0);
    chk(irq, 1'b1);
    wb(1'b1, ADDR_IRQ_STAT, 32'h1); repeat (2) @(posedge clk); chk(irq, 1'b0);
    step(16'h0005, 16'h0e10); chk(sw[0], 1'b1);
    step(16'h00c8, 16'h0e10); chk(sw[0], 1'b0);
    // Every precharge FET selector code
    for (i = 0; i < 4; i++) begin
      wb(1'b1, ADDR_CTRL, i << 2);
      step(16'h0032, 16'h0e10);
      chk({sw[1], seen_cur}, {1'b1, 16'h00fa});
      chk({open_drain_pin, zero_volt_charge_fet}, (i == 0) ? 2'h1 : (i == 2) ? 2'h2 : 2'h0);
      if (i == 1) chk(charge_fet, 1'b1);
    end
    chk(irq, 1'b0);
    // Precharge exit needs both hysteresis and recovery
    step(16'h007d, 16'h0e10); chk(sw[1], 1'b1);
    step(16'h00c8, 16'h0bea); chk(sw[1], 1'b1);
    step(16'h00c8, 16'h0c80); chk(sw[1], 1'b0);
    step(16'h00c8, 16'h0c80); chk({sw[2], charge_fet}, 2'h3);
    wb(1'b0, ADDR_REQ, 32'h0); chk(q, 32'h41a00fa0);
    // Each safety flag forces precharge
    for (i = 0; i < 4; i++) begin
      sflags <= 4'h1 << i;
      step(16'h00c8, 16'h0e10); chk(sw[1], 1'b1);
      sflags <= 4'h0;
      step(16'h00c8, 16'h0e10);
    end
    // Fault, suspend and removal end precharge
    for (i = 0; i < 3; i++) begin
      step(16'h00c8, 16'h0b54);
      stop_src <= 3'h1 << i;
      step(16'h00c8, 16'h0b54); chk(sw[1], 1'b0);
      stop_src <= 3'h0;
    end
    step(16'hfff6, 16'h0e10); stop_src <= 3'h1;
    step(16'hfff6, 16'h0e10); chk(sw[0], 1'b0);
    stop_src <= 3'h0;
    // Pack voltage limit for fast charge
    pack_voltage <= 16'h4395; step(16'h00c8, 16'h0e10); step(16'h00c8, 16'h0e10); chk(sw[2], 1'b0);
    pack_voltage <= 16'h4394; step(16'h012c, 16'h0e10); chk(sw[2], 1'b1);
    // Throttle bands with extra hysteresis
    wb(1'b1, ADDR_INH_HI, 32'h02bc);
    step(16'h01c7, 16'h0e10); chk({sw[4:3], seen_cur}, {2'h0, 16'h0fa0});
    step(16'h01d1, 16'h0e10); chk({sw[4:3], seen_cur}, {2'h2, 16'h0753});
    step(16'h01f9, 16'h0e10); chk(sw[4:3], 2'h2);
    step(16'h0203, 16'h0e10); chk({sw[4:3], seen_cur}, {2'h1, 16'h00fa});
    prot <= 1'b1; step(16'h0203, 16'h0e10); chk({sw[4:3], charge_fet}, 3'h0);
    prot <= 1'b0; step(16'h012c, 16'h0e10); chk({sw[4:3], seen_cur}, {2'h0, 16'h0fa0});
    // Zero delta keeps full current
    wb(1'b1, ADDR_DELTA, 32'h0);
    step(16'h0203, 16'h0e10); chk({sw[4:2], seen_cur}, {3'h1, 16'h0fa0});
    wrap_up();
  end
endmodule
// Checker beside the top module
bind cmc_charge_mode_controller cmc_charge_mode_controller_props u_props (.clk(clk), .reset_n(reset_n),
  .tick(tick), .fault_detected(fault_detected), .protection_detected(protection_detected),
  .suspend_entry(suspend_entry), .battery_removed(battery_removed), .cell_undervolt_flag(cell_undervolt_flag),
  .pack_undervolt_flag(pack_undervolt_flag), .discharge_overcurrent_flag(discharge_overcurrent_flag),
  .discharge_overcurrent_tier2_flag(discharge_overcurrent_tier2_flag), .charging_current(charging_current),
  .charging_voltage(charging_voltage), .charge_state_word(charge_state_word), .charge_fet(charge_fet),
  .wb_ack_o(wb_ack_o));
